// ===== rtl/adsc_cfg.svh
// Constants for the auxiliary drive speed control block
`ifndef ADSC_CFG_SVH
`define ADSC_CFG_SVH
`define ADSC_CLK_NS 32'h0000_0064
`define ADSC_MS_NS 32'h000f_4240
`define ADSC_HOLD_MS 10'h1f4
`define ADSC_RAMP_MS 5'h14
`define ADSC_TAMPER_MS 16'h7530
`define ADSC_OFF_CTRL 5'h00
`define ADSC_OFF_RESUME 5'h04
`define ADSC_OFF_LOWER 5'h08
`define ADSC_OFF_UPPER 5'h0c
`define ADSC_OFF_STEP 5'h10
`define ADSC_OFF_VLIM 5'h14
`define ADSC_OFF_STATUS 5'h18
`define ADSC_OFF_SETSPD 5'h1c
`define ADSC_CTRL_EN 0
`define ADSC_CTRL_OUT_EN 1
`define ADSC_CTRL_BRAKE 2
`define ADSC_CTRL_PARK 3
`define ADSC_CTRL_OUT_PARK 4
`define ADSC_CTRL_WSTART 5
`define ADSC_RST_CTRL 6'h17
`define ADSC_RST_RESUME 12'h2ee
`define ADSC_RST_LOWER 12'h1f4
`define ADSC_RST_UPPER 12'h9c4
`define ADSC_RST_STEP 8'h32
`define ADSC_RST_VLIM 8'h0c
`define ADSC_RPM_MIN 12'h1f4
`define ADSC_RPM_MAX 12'h9c4
`define ADSC_STEP_MIN 16'h0001
`define ADSC_STEP_MAX 16'h00fa
`define ADSC_VLIM_MAX 16'h001e
`endif

// ===== rtl/adsc_pkg.sv
// Types for the auxiliary drive speed control block
package adsc_pkg;
  typedef logic [11:0] adsc_rpm_t;
  typedef logic [15:0] adsc_word_t;
  typedef logic [7:0] adsc_byte_t;
  typedef enum logic [1:0]
  {
    ADSC_BTN_IDLE = 2'b00,
    ADSC_BTN_PRESS = 2'b01,
    ADSC_BTN_RAMP = 2'b11
  } adsc_btn_t;
endpackage : adsc_pkg

// ===== rtl/adsc_top.sv
// Auxiliary drive gating and stationary engine speed control
//
// Design decisions made here: the plain strobed port and the address map.
`include "adsc_cfg.svh"
module adsc_top #(
  parameter int unsigned P_MS_CYC = `ADSC_MS_NS / `ADSC_CLK_NS,
  parameter int unsigned P_TAMPER_MS = `ADSC_TAMPER_MS
)
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [4:0] i_addr,
  input wire adsc_pkg::adsc_word_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output adsc_pkg::adsc_word_t o_rdata,
  input wire logic i_key_on,
  input wire logic i_cc_on,
  input wire logic i_resume,
  input wire logic i_set_inc,
  input wire logic i_set_dec,
  input wire logic i_remote_inc,
  input wire logic i_remote_dec,
  input wire logic i_brake,
  input wire logic i_park_brake,
  input wire logic i_enable_in,
  input wire adsc_pkg::adsc_rpm_t i_eng_rpm,
  input wire logic i_eng_fault,
  input wire adsc_pkg::adsc_byte_t i_veh_kmh,
  input wire logic i_vss_fault,
  input wire logic i_accel_override,
  input wire adsc_pkg::adsc_rpm_t i_accel_rpm,
  input wire adsc_pkg::adsc_byte_t i_accel_pos,
  output logic o_speed_ctl_active,
  output adsc_pkg::adsc_rpm_t o_speed_req,
  output logic o_aux_drive_n,
  output logic o_tamper_release
);
  import adsc_pkg::*;

  logic [5:0] ctrl_reg;
  adsc_rpm_t resume_reg;
  adsc_rpm_t lower_reg;
  adsc_rpm_t upper_reg;
  adsc_byte_t step_reg;
  adsc_byte_t vlim_reg;
  logic [15:0] ms_cnt_reg;
  logic ms_tick_reg;
  logic armed_reg;
  logic resume_d_reg;
  logic wreq_d_reg;
  logic active_reg;
  logic wired_src_reg;
  adsc_rpm_t set_reg;
  adsc_btn_t btn_reg;
  logic dir_dn_reg;
  logic [9:0] hold_reg;
  logic [4:0] ramp_reg;
  logic brake_d_reg;
  adsc_byte_t pos_d_reg;
  logic [15:0] tamper_reg;

  // Register writes, out of range values are dropped
  wire adsc_rpm_t wd_rpm = i_wdata[11:0];
  wire wd_hi_zero = (i_wdata[15:12] == 4'h0);
  wire rpm_in_win = wd_hi_zero && (wd_rpm >= `ADSC_RPM_MIN) && (wd_rpm <= `ADSC_RPM_MAX);
  wire wr_ctrl = i_wr && (i_addr == `ADSC_OFF_CTRL);
  wire wr_resume = i_wr && (i_addr == `ADSC_OFF_RESUME) && wd_hi_zero &&
    (wd_rpm >= lower_reg) && (wd_rpm <= upper_reg);
  wire wr_lower = i_wr && (i_addr == `ADSC_OFF_LOWER) && rpm_in_win &&
    (wd_rpm < upper_reg) && (wd_rpm <= resume_reg);
  wire wr_upper = i_wr && (i_addr == `ADSC_OFF_UPPER) && rpm_in_win &&
    (wd_rpm > lower_reg) && (wd_rpm >= resume_reg);
  wire wr_step = i_wr && (i_addr == `ADSC_OFF_STEP) &&
    (i_wdata >= `ADSC_STEP_MIN) && (i_wdata <= `ADSC_STEP_MAX);
  wire wr_vlim = i_wr && (i_addr == `ADSC_OFF_VLIM) && (i_wdata <= `ADSC_VLIM_MAX);

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      ctrl_reg <= `ADSC_RST_CTRL;
      resume_reg <= `ADSC_RST_RESUME;
      lower_reg <= `ADSC_RST_LOWER;
      upper_reg <= `ADSC_RST_UPPER;
      step_reg <= `ADSC_RST_STEP;
      vlim_reg <= `ADSC_RST_VLIM;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= i_wdata[5:0];
      if (wr_resume)
        resume_reg <= wd_rpm;
      if (wr_lower)
        lower_reg <= wd_rpm;
      if (wr_upper)
        upper_reg <= wd_rpm;
      if (wr_step)
        step_reg <= i_wdata[7:0];
      if (wr_vlim)
        vlim_reg <= i_wdata[7:0];
    end
  end

  // Millisecond enable for the button and tamper timers
  wire ms_wrap = (ms_cnt_reg == 16'(P_MS_CYC - 1));

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      ms_cnt_reg <= 16'h0000;
      ms_tick_reg <= 1'b0;
    end
    else
    begin
      ms_cnt_reg <= ms_wrap ? 16'h0000 : ms_cnt_reg + 16'h0001;
      ms_tick_reg <= ms_wrap;
    end
  end

  // Activation conditions
  wire veh_ok = (i_veh_kmh <= vlim_reg) && !i_vss_fault;
  wire eng_ok = (i_eng_rpm != 12'h000) && !i_eng_fault;
  wire wired_ok = ctrl_reg[`ADSC_CTRL_EN] && i_cc_on && i_enable_in && armed_reg &&
    eng_ok && veh_ok;
  // Service brake deliberately absent here
  wire drive_next = wired_ok && ctrl_reg[`ADSC_CTRL_OUT_EN] &&
    (!ctrl_reg[`ADSC_CTRL_OUT_PARK] || i_park_brake);
  wire spd_ok = i_cc_on && veh_ok &&
    (!ctrl_reg[`ADSC_CTRL_BRAKE] || !i_brake) &&
    (!ctrl_reg[`ADSC_CTRL_PARK] || i_park_brake);
  wire wired_req = wired_ok && ctrl_reg[`ADSC_CTRL_WSTART];
  wire resume_rise = i_resume && !resume_d_reg;
  wire wired_rise = wired_req && !wreq_d_reg;
  wire engage = !active_reg && spd_ok && (resume_rise || wired_rise);
  wire drop = !spd_ok || (wired_src_reg && !wired_req);

  // Key cycle arming stops a stuck enable switch
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      armed_reg <= 1'b0;
    else if (!i_key_on)
      armed_reg <= 1'b0;
    else if (!i_enable_in)
      armed_reg <= 1'b1;
  end

  // Buttons, remote ones only with park brake set
  wire btn_inc = i_set_inc || (i_remote_inc && i_park_brake);
  wire btn_dec = i_set_dec || (i_remote_dec && i_park_brake);
  wire btn_press = btn_inc ^ btn_dec;
  wire tap_pulse = (btn_reg == ADSC_BTN_PRESS) && !btn_press;
  wire hold_done = ms_tick_reg && (hold_reg == `ADSC_HOLD_MS - 10'h001);
  wire ramp_pulse = (btn_reg == ADSC_BTN_RAMP) && btn_press && ms_tick_reg &&
    (ramp_reg == `ADSC_RAMP_MS - 5'h01);

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      btn_reg <= ADSC_BTN_IDLE;
      dir_dn_reg <= 1'b0;
      hold_reg <= 10'h000;
      ramp_reg <= 5'h00;
    end
    else
    begin
      unique case (btn_reg)
        ADSC_BTN_IDLE:
        begin
          hold_reg <= 10'h000;
          ramp_reg <= 5'h00;
          dir_dn_reg <= btn_dec;
          if (btn_press)
            btn_reg <= ADSC_BTN_PRESS;
        end
        ADSC_BTN_PRESS:
        begin
          if (!btn_press)
            btn_reg <= ADSC_BTN_IDLE;
          else if (hold_done)
            btn_reg <= ADSC_BTN_RAMP;
          else if (ms_tick_reg)
            hold_reg <= hold_reg + 10'h001;
        end
        ADSC_BTN_RAMP:
        begin
          if (!btn_press)
            btn_reg <= ADSC_BTN_IDLE;
          else if (ms_tick_reg)
            ramp_reg <= ramp_pulse ? 5'h00 : ramp_reg + 5'h01;
        end
        default:
          btn_reg <= ADSC_BTN_IDLE;
      endcase
    end
  end

  // Tap uses the step, ramp moves one RPM per interval
  wire adsc_byte_t amt = tap_pulse ? step_reg : 8'h01;
  wire [12:0] up_val = {1'b0, set_reg} + {5'h00, amt};
  wire [12:0] dn_val = {1'b0, set_reg} - {5'h00, amt};
  wire dn_under = dn_val[12] || (dn_val[11:0] < lower_reg);
  wire adsc_rpm_t up_clamp = (up_val > {1'b0, upper_reg}) ? upper_reg : up_val[11:0];
  wire adsc_rpm_t dn_clamp = dn_under ? lower_reg : dn_val[11:0];
  wire adjust = active_reg && !drop && (tap_pulse || ramp_pulse);
  wire adsc_rpm_t set_next = engage ? resume_reg :
    (adjust ? (dir_dn_reg ? dn_clamp : up_clamp) : set_reg);
  wire override = i_accel_override && (i_accel_rpm > set_reg);
  // Pedal demand is passed through unbounded
  wire adsc_rpm_t req_next = !active_reg ? 12'h000 :
    (override ? i_accel_rpm : set_reg);

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      resume_d_reg <= 1'b0;
      wreq_d_reg <= 1'b0;
      active_reg <= 1'b0;
      wired_src_reg <= 1'b0;
      set_reg <= `ADSC_RST_RESUME;
    end
    else
    begin
      resume_d_reg <= i_resume;
      wreq_d_reg <= wired_req;
      set_reg <= set_next;
      if (engage)
      begin
        active_reg <= 1'b1;
        wired_src_reg <= wired_rise && !resume_rise;
      end
      else if (drop)
      begin
        active_reg <= 1'b0;
        wired_src_reg <= 1'b0;
      end
    end
  end

  // Tamper timer, restarts on any pedal movement
  wire pedal_held = i_brake || (i_accel_pos != 8'h00);
  wire pedal_moved = (i_brake != brake_d_reg) || (i_accel_pos != pos_d_reg);
  wire tamper_full = (tamper_reg == 16'(P_TAMPER_MS));

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      brake_d_reg <= 1'b0;
      pos_d_reg <= 8'h00;
      tamper_reg <= 16'h0000;
    end
    else
    begin
      brake_d_reg <= i_brake;
      pos_d_reg <= i_accel_pos;
      if (!pedal_held || pedal_moved)
        tamper_reg <= 16'h0000;
      else if (ms_tick_reg && !tamper_full)
        tamper_reg <= tamper_reg + 16'h0001;
    end
  end

  // Register read path, one cycle latency
  wire adsc_word_t status_word = {10'h000, btn_press, spd_ok, wired_ok, armed_reg,
    !o_aux_drive_n, active_reg};
  wire adsc_word_t rd_mux =
    (i_addr == `ADSC_OFF_CTRL) ? {10'h000, ctrl_reg} :
    (i_addr == `ADSC_OFF_RESUME) ? {4'h0, resume_reg} :
    (i_addr == `ADSC_OFF_LOWER) ? {4'h0, lower_reg} :
    (i_addr == `ADSC_OFF_UPPER) ? {4'h0, upper_reg} :
    (i_addr == `ADSC_OFF_STEP) ? {8'h00, step_reg} :
    (i_addr == `ADSC_OFF_VLIM) ? {8'h00, vlim_reg} :
    (i_addr == `ADSC_OFF_STATUS) ? status_word :
    (i_addr == `ADSC_OFF_SETSPD) ? {4'h0, set_reg} : 16'h0000;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_rdata <= 16'h0000;
      o_speed_ctl_active <= 1'b0;
      o_speed_req <= 12'h000;
      o_aux_drive_n <= 1'b1;
      o_tamper_release <= 1'b0;
    end
    else
    begin
      o_rdata <= i_rd ? rd_mux : 16'h0000;
      o_speed_ctl_active <= active_reg;
      o_speed_req <= req_next;
      o_aux_drive_n <= !drive_next;
      o_tamper_release <= pedal_held && !pedal_moved && tamper_full;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_resume_engage;
    !active_reg && spd_ok && resume_rise;
  endsequence

  sequence s_tap_up;
    active_reg && spd_ok && tap_pulse && !dir_dn_reg &&
      (up_val <= {1'b0, upper_reg});
  endsequence

  a_resume_target: assert property (s_resume_engage |=> active_reg ##1 o_speed_ctl_active)
    else $error("resume did not engage");
  a_resume_value: assert property (s_resume_engage |=> set_reg == $past(resume_reg))
    else $error("resume target not loaded");
  a_tap_step: assert property (s_tap_up |=> set_reg == $past(set_reg) + 12'($past(step_reg)))
    else $error("tap step wrong");
  a_ramp_one: assert property ((active_reg && spd_ok && ramp_pulse && dir_dn_reg &&
    !dn_under) |=> set_reg == $past(set_reg) - 12'h001)
    else $error("ramp step wrong");
  a_set_upper: assert property ((active_reg && adjust && !dir_dn_reg) |=> set_reg <= upper_reg)
    else $error("set speed above bound");
  a_brake_drop: assert property ((ctrl_reg[`ADSC_CTRL_BRAKE] && i_brake) |=> !active_reg ##1
    !o_speed_ctl_active)
    else $error("brake did not drop control");
  a_park_drop: assert property ((ctrl_reg[`ADSC_CTRL_PARK] && !i_park_brake) |=> !active_reg)
    else $error("park brake did not drop control");
  a_veh_drop: assert property ((i_veh_kmh > vlim_reg) |=> !active_reg && o_aux_drive_n)
    else $error("vehicle speed did not drop");
  a_master_off: assert property (!ctrl_reg[`ADSC_CTRL_EN] |=> o_aux_drive_n)
    else $error("drive without master enable");
  a_out_gate: assert property (!ctrl_reg[`ADSC_CTRL_OUT_EN] |=> o_aux_drive_n)
    else $error("drive without output enable");
  a_cc_eng_gate: assert property ((!i_cc_on || i_eng_rpm == 12'h000) |=> o_aux_drive_n)
    else $error("drive with cruise off or engine stopped");
  a_arm_gate: assert property (!armed_reg |=> o_aux_drive_n)
    else $error("drive before enable seen off");
  a_drive_on: assert property (drive_next |=> !o_aux_drive_n)
    else $error("drive output not low");
  a_remote_park: assert property ((!i_park_brake && !i_set_inc && !i_set_dec) |-> !btn_press)
    else $error("remote button without park brake");
  a_accel_over: assert property ((active_reg && override) |=> o_speed_req == $past(i_accel_rpm))
    else $error("pedal override not passed");
  a_tamper_move: assert property (pedal_moved |=> !o_tamper_release && tamper_reg == 16'h0000)
    else $error("tamper release after pedal moved");
endmodule : adsc_top

// ===== dv/adsc_engine_model.sv
// Engine model that answers the speed request at the far side
module adsc_engine_model
(
  input wire logic i_clk,
  input wire logic i_key_on,
  input wire logic i_stall,
  input wire adsc_pkg::adsc_rpm_t i_speed_req,
  output adsc_pkg::adsc_rpm_t o_eng_rpm
);
  import adsc_pkg::*;
  // Idles at 600 when nothing is requested, stops with the key off
  always_ff @(posedge i_clk)
  begin
    if (!i_key_on || i_stall)
      o_eng_rpm <= 12'h000;
    else if (i_speed_req != 12'h000)
      o_eng_rpm <= i_speed_req;
    else
      o_eng_rpm <= 12'h258;
  end
endmodule : adsc_engine_model

// ===== dv/test_auxiliary_drive_speed_control.sv
// Self-checking bench for the auxiliary drive speed control block
module test_auxiliary_drive_speed_control;
  timeunit 1ns;
  timeprecision 1ns;
  import adsc_pkg::*;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [4:0] i_addr = 5'h00;
  adsc_word_t i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  adsc_word_t o_rdata;
  logic key = 1'b1, cc = 1'b1, resume = 1'b0, brake = 1'b0, park = 1'b0, en_in = 1'b0;
  logic stall = 1'b0, eng_flt = 1'b0, vss_flt = 1'b0, ovr = 1'b0;
  logic [3:0] btn = 4'h0;
  adsc_byte_t kmh = 8'h00;
  adsc_byte_t acc_pos = 8'h00;
  adsc_rpm_t acc_rpm = 12'h000;
  adsc_rpm_t rpm, req;
  logic active, drv_n, tamper;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;

  adsc_engine_model i_eng (.i_clk(i_clk), .i_key_on(key), .i_stall(stall), .i_speed_req(req), .o_eng_rpm(rpm));
  adsc_top #(.P_MS_CYC(10), .P_TAMPER_MS(5)) i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_key_on(key), .i_cc_on(cc),
    .i_resume(resume), .i_set_inc(btn[0]), .i_set_dec(btn[1]), .i_remote_inc(btn[2]), .i_remote_dec(btn[3]),
    .i_brake(brake), .i_park_brake(park), .i_enable_in(en_in), .i_eng_rpm(rpm), .i_eng_fault(eng_flt),
    .i_veh_kmh(kmh), .i_vss_fault(vss_flt), .i_accel_override(ovr), .i_accel_rpm(acc_rpm),
    .i_accel_pos(acc_pos), .o_speed_ctl_active(active), .o_speed_req(req), .o_aux_drive_n(drv_n),
    .o_tamper_release(tamper));

  always #50 i_clk = ~i_clk;

  task automatic print_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  // Ceiling well above the ramp hold, which dominates the run
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc_n(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc_n

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp, input string what);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(what, o_rdata, exp);
  endtask : rd_chk

  task automatic tap(input int i);
    @(posedge i_clk);
    btn[i] <= 1'b1;
    cyc_n(10);
    btn[i] <= 1'b0;
    cyc_n(4);
  endtask : tap

  task automatic pulse_resume;
    @(posedge i_clk);
    resume <= 1'b1;
    cyc_n(2);
    resume <= 1'b0;
    cyc_n(4);
  endtask : pulse_resume

  task automatic t_regs;
    chk("drive at reset", {15'h0000, drv_n}, 16'h0001);
    rd_chk(5'h00, 16'h0017, "ctrl");
    rd_chk(5'h04, 16'h02ee, "resume");
    rd_chk(5'h08, 16'h01f4, "lower");
    rd_chk(5'h0c, 16'h09c4, "upper");
    rd_chk(5'h10, 16'h0032, "step");
    rd_chk(5'h14, 16'h000c, "vlim");
    wr(5'h10, 16'h0000);
    rd_chk(5'h10, 16'h0032, "step zero");
    wr(5'h10, 16'h00fb);
    rd_chk(5'h10, 16'h0032, "step 251");
    wr(5'h10, 16'h0064);
    rd_chk(5'h10, 16'h0064, "step 100");
    cyc_n(1);
    #1 chk("rdata idle", o_rdata, 16'h0000);
    wr(5'h10, 16'h0032);
    wr(5'h14, 16'h001f);
    rd_chk(5'h14, 16'h000c, "vlim 31");
    wr(5'h08, 16'h09c4);
    rd_chk(5'h08, 16'h01f4, "lower at upper");
    wr(5'h04, 16'h01f3);
    rd_chk(5'h04, 16'h02ee, "resume below");
    rd_chk(5'h1e, 16'h0000, "unmapped");
    $display("test regs done");
  endtask : t_regs

  task automatic t_adjust;
    pulse_resume();
    chk("active", {15'h0000, active}, 16'h0001);
    chk("resume speed", {4'h0, req}, 16'h02ee);
    tap(0);
    chk("tap inc", {4'h0, req}, 16'h0320);
    rd_chk(5'h1c, 16'h0320, "set speed");
    tap(1);
    chk("tap dec", {4'h0, req}, 16'h02ee);
    tap(2);
    chk("remote no park", {4'h0, req}, 16'h02ee);
    park <= 1'b1;
    tap(2);
    chk("remote inc", {4'h0, req}, 16'h0320);
    tap(3);
    chk("remote dec", {4'h0, req}, 16'h02ee);
    wr(5'h10, 16'h00fa);
    tap(1);
    tap(1);
    chk("clamp lower", {4'h0, req}, 16'h01f4);
    wr(5'h10, 16'h0032);
    @(posedge i_clk);
    ovr <= 1'b1;
    acc_rpm <= 12'hbb8;
    cyc_n(4);
    chk("override", {4'h0, req}, 16'h0bb8);
    ovr <= 1'b0;
    btn[0] <= 1'b1;
    // 500 ms hold threshold, then 200 ms of ramp at 1 RPM per 20 ms
    cyc_n(7000);
    btn[0] <= 1'b0;
    cyc_n(4);
    chk("ramp", {15'h0000, req >= 12'h1f7 && req <= 12'h205}, 16'h0001);
    // Long enough down ramp to run into the lower bound
    btn[1] <= 1'b1;
    cyc_n(9000);
    btn[1] <= 1'b0;
    cyc_n(4);
    chk("ramp down clamp", {4'h0, req}, 16'h01f4);
    $display("test adjust done");
  endtask : t_adjust

  task automatic t_drop;
    kmh <= 8'h0c;
    cyc_n(4);
    chk("at limit", {15'h0000, active}, 16'h0001);
    kmh <= 8'h0d;
    cyc_n(4);
    chk("over limit", {3'h0, active, req}, 16'h0000);
    kmh <= 8'h00;
    pulse_resume();
    brake <= 1'b1;
    cyc_n(4);
    chk("brake drop", {15'h0000, active}, 16'h0000);
    brake <= 1'b0;
    wr(5'h00, 16'h0013);
    pulse_resume();
    brake <= 1'b1;
    cyc_n(4);
    chk("brake ignored", {15'h0000, active}, 16'h0001);
    brake <= 1'b0;
    wr(5'h00, 16'h001f);
    park <= 1'b0;
    cyc_n(4);
    chk("park drop", {15'h0000, active}, 16'h0000);
    park <= 1'b1;
    wr(5'h00, 16'h0017);
    $display("test drop done");
  endtask : t_drop

  task automatic fault(input int i, input logic on);
    @(posedge i_clk);
    case (i)
      0: stall <= on;
      1: eng_flt <= on;
      2: kmh <= on ? 8'h0d : 8'h00;
      3: vss_flt <= on;
      4: cc <= !on;
      5: park <= !on;
      6: brake <= on;
      7: wr(5'h00, on ? 16'h0016 : 16'h0017);
      default: wr(5'h00, on ? 16'h0015 : 16'h0017);
    endcase
    cyc_n(4);
  endtask : fault

  task automatic t_wired;
    @(posedge i_clk);
    en_in <= 1'b1;
    cyc_n(4);
    chk("drive on", {15'h0000, drv_n}, 16'h0000);
    rd_chk(5'h18, 16'h001e, "status");
    for (int i = 0; i < 9; i++)
    begin
      fault(i, 1'b1);
      chk("drive gated", {15'h0000, drv_n}, (i == 6) ? 16'h0000 : 16'h0001);
      fault(i, 1'b0);
    end
    key <= 1'b0;
    cyc_n(4);
    key <= 1'b1;
    cyc_n(4);
    chk("stuck switch", {15'h0000, drv_n}, 16'h0001);
    en_in <= 1'b0;
    cyc_n(4);
    en_in <= 1'b1;
    cyc_n(4);
    chk("rearmed", {15'h0000, drv_n}, 16'h0000);
    wr(5'h00, 16'h0007);
    park <= 1'b0;
    cyc_n(4);
    chk("output park off", {15'h0000, drv_n}, 16'h0000);
    park <= 1'b1;
    wr(5'h00, 16'h0017);
    $display("test wired done");
  endtask : t_wired

  task automatic t_wstart;
    en_in <= 1'b0;
    wr(5'h00, 16'h0037);
    brake <= 1'b1;
    cyc_n(4);
    brake <= 1'b0;
    cyc_n(4);
    chk("idle", {15'h0000, active}, 16'h0000);
    en_in <= 1'b1;
    cyc_n(4);
    chk("wired start", {3'h0, active, req}, 16'h12ee);
    en_in <= 1'b0;
    cyc_n(4);
    chk("wired stop", {15'h0000, active}, 16'h0000);
    wr(5'h00, 16'h0017);
    brake <= 1'b1;
    cyc_n(30);
    chk("tamper early", {15'h0000, tamper}, 16'h0000);
    cyc_n(50);
    chk("tamper set", {15'h0000, tamper}, 16'h0001);
    acc_pos <= 8'h40;
    cyc_n(2);
    chk("accel moved", {15'h0000, tamper}, 16'h0000);
    brake <= 1'b0;
    cyc_n(80);
    chk("accel held", {15'h0000, tamper}, 16'h0001);
    acc_pos <= 8'h00;
    cyc_n(4);
    chk("tamper clear", {15'h0000, tamper}, 16'h0000);
    $display("test wired start and tamper done");
  endtask : t_wstart

  initial
  begin
    cyc_n(12);
    i_sys_rst <= 1'b0;
    t_regs();
    t_adjust();
    t_drop();
    t_wired();
    t_wstart();
    print_verdict();
  end
endmodule : test_auxiliary_drive_speed_control
